/* sscf_pkg.sv */
package sscf_pkg;

  // register indices; byte address is four times the index
  localparam logic [3:0] IDX_DATA          = 4'h0;
  localparam logic [3:0] IDX_FEATURE_ERROR = 4'h1;
  localparam logic [3:0] IDX_SECTOR_COUNT  = 4'h2;
  localparam logic [3:0] IDX_SECTOR_NUMBER = 4'h3;
  localparam logic [3:0] IDX_CYLINDER_LOW  = 4'h4;
  localparam logic [3:0] IDX_CYLINDER_HIGH = 4'h5;
  localparam logic [3:0] IDX_DRIVE_HEAD    = 4'h6;
  localparam logic [3:0] IDX_CMD_STATUS    = 4'h7;
  localparam logic [3:0] IDX_CONFIG        = 4'h8;
  localparam logic [3:0] IDX_SEC_STATE     = 4'h9;
  localparam int unsigned IDX_LSB          = 2;
  localparam int unsigned MAP_MSB          = 5;

  // opcodes
  localparam logic [7:0] CMD_SET_PWD       = 8'hF1;
  localparam logic [7:0] CMD_UNLOCK        = 8'hF2;
  localparam logic [7:0] CMD_ERASE_PREP    = 8'hF3;
  localparam logic [7:0] CMD_ERASE_UNIT    = 8'hF4;
  localparam logic [7:0] CMD_FREEZE        = 8'hF5;
  localparam logic [3:0] CMD_SEEK_HI       = 4'h7;

  // status and error bit positions
  localparam int unsigned STS_BSY          = 7;
  localparam int unsigned STS_DRDY         = 6;
  localparam int unsigned STS_DRQ          = 3;
  localparam int unsigned STS_ERR          = 0;
  localparam int unsigned ERR_ABRT         = 2;
  localparam int unsigned ERR_IDNF         = 4;

  // parameter sector layout
  localparam int unsigned CTRL_ID_BIT      = 0;
  localparam int unsigned CTRL_LVL_BIT     = 8;
  localparam int unsigned PWD_WORDS        = 16;
  localparam int unsigned DH_LBA_BIT       = 6;

  // configuration and reset values
  localparam int unsigned CFG_SEC_EN       = 0;
  localparam logic [7:0]  CFG_RESET        = 8'h01;
  localparam logic [2:0]  UNLOCK_TRIES     = 3'h5;
  localparam logic [7:0]  TF_RESET         = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DATA = 2'b01,
    ST_EXEC = 2'b10
  } sscf_state_t;

  typedef struct packed {
    logic [7:0] feature;
    logic [7:0] sec_cnt;
    logic [7:0] sec_num;
    logic [7:0] cyl_lo;
    logic [7:0] cyl_hi;
    logic [7:0] dh;
  } sscf_taskfile_t;

  typedef struct packed {
    logic       frozen;
    logic       locked;
    logic       lock_en;
    logic       level_max;
    logic [2:0] tries;
  } sscf_secstate_t;

endpackage

/* sscf_security_cmd.sv */
// What this block does
// - erase unit takes one sector; aborts when the password does not match
// - erase unit aborts unless the previous command was a completed erase prepare
// - freeze lock puts the device into frozen state
// - frozen: set password, unlock, erase unit are aborted
// - frozen clears only by power-on or hardware reset
// - freeze lock while frozen completes normally and stays frozen
// - freeze lock completion writes zero into sector count
// - without security feature set, freeze opcode runs as wear-level command
// - set password sector: word0 bit0 id, bit8 level, words 1-16 password
// - user high: store user password, lock from next reset, user or master unlocks
// - user maximum: store user password, lock next reset, only user unlocks
// - master id: store master password, lock enable and level unchanged
// - unlock master: compare at high level, reject at maximum level
// - unlock user: compare against stored user password
// - attempt counter starts at five, decrements on failed unlock compare while locked
// - counter zero aborts unlock and erase unit until reset
// - unlock while unlocked leaves the counter unchanged
// - seek only range-checks the address and reports out-of-range errors
//
// The AHB-Lite interface to the registers is this design's own decision.
module sscf_security_cmd #(
  parameter int unsigned ADDR_W       = 32,
  parameter int unsigned SECTOR_WORDS = 256,
  parameter int unsigned NUM_CYL      = 980,
  parameter int unsigned NUM_HEAD     = 16,
  parameter int unsigned NUM_SPT      = 32
) (
  // clock and resets
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              por_n,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // events
  output logic                   intrq,
  output logic                   erase_pulse,
  output logic                   wear_level_pulse
);

  localparam int unsigned WC_W = $clog2(SECTOR_WORDS);
  localparam logic [27:0] TOTAL_LBA = 28'(NUM_CYL * NUM_HEAD * NUM_SPT);
  localparam logic [WC_W-1:0] LAST_WORD = WC_W'(SECTOR_WORDS - 1);

  sscf_pkg::sscf_state_t    state_ff;
  sscf_pkg::sscf_state_t    nxt_state;
  sscf_pkg::sscf_taskfile_t tf_ff;
  sscf_pkg::sscf_secstate_t sec_w;
  logic [7:0]               cmd_ff;
  logic [7:0]               cfg_ff;
  logic [15:0]              ctrl_ff;
  logic [255:0]             pwd_buf_ff;
  logic [255:0]             user_pwd_ff;
  logic [255:0]             master_pwd_ff;
  logic [WC_W-1:0]          word_cnt_ff;
  logic                     wr_pend_ff;
  logic [3:0]               wr_idx_ff;
  logic                     bsy_ff;
  logic                     drq_ff;
  logic                     err_ff;
  logic                     abrt_ff;
  logic                     idnf_ff;
  logic                     frozen_ff;
  logic                     locked_ff;
  logic                     load_lock_ff;
  logic                     lock_en_ff;
  logic                     level_max_ff;
  logic                     prep_ok_ff;
  logic [2:0]               tries_ff;
  logic                     x_abort;
  logic                     x_idnf;

  // bus decode
  wire        acc      = hsel & htrans[1] & hready;
  wire        mapped   = (haddr[ADDR_W-1:sscf_pkg::MAP_MSB+1] == '0);
  wire [3:0]  a_idx    = mapped ? haddr[sscf_pkg::MAP_MSB:sscf_pkg::IDX_LSB] : 4'hF;
  wire        rd_acc   = acc & ~hwrite;
  wire        wr_en    = wr_pend_ff;
  wire        sts_rd   = rd_acc & (a_idx == sscf_pkg::IDX_CMD_STATUS);
  wire        cmd_go   = wr_en & (wr_idx_ff == sscf_pkg::IDX_CMD_STATUS) & (state_ff == sscf_pkg::ST_IDLE);
  wire        data_go  = wr_en & (wr_idx_ff == sscf_pkg::IDX_DATA) & (state_ff == sscf_pkg::ST_DATA);
  wire        tf_wr    = wr_en & ~bsy_ff & ~drq_ff;
  wire [7:0]  wbyte    = hwdata[7:0];
  wire        last_w   = data_go & (word_cnt_ff == LAST_WORD);
  wire        in_exec  = (state_ff == sscf_pkg::ST_EXEC);
  wire        sec_en   = cfg_ff[sscf_pkg::CFG_SEC_EN];

  function automatic logic needs_sector(input logic [7:0] op);
    return (op == sscf_pkg::CMD_SET_PWD) | (op == sscf_pkg::CMD_UNLOCK) | (op == sscf_pkg::CMD_ERASE_UNIT);
  endfunction

  // status and error bytes
  wire [7:0] status_byte = 8'h00 | (8'(bsy_ff) << sscf_pkg::STS_BSY) | (8'(~bsy_ff) << sscf_pkg::STS_DRDY)
                         | (8'(drq_ff) << sscf_pkg::STS_DRQ) | (8'(err_ff) << sscf_pkg::STS_ERR);
  wire [7:0] error_byte  = (8'(abrt_ff) << sscf_pkg::ERR_ABRT) | (8'(idnf_ff) << sscf_pkg::ERR_IDNF);
  assign sec_w = '{frozen: frozen_ff, locked: locked_ff, lock_en: lock_en_ff,
                   level_max: level_max_ff, tries: tries_ff};

  wire [7:0] rd_byte =
      (a_idx == sscf_pkg::IDX_FEATURE_ERROR) ? error_byte :
      (a_idx == sscf_pkg::IDX_SECTOR_COUNT)  ? tf_ff.sec_cnt :
      (a_idx == sscf_pkg::IDX_SECTOR_NUMBER) ? tf_ff.sec_num :
      (a_idx == sscf_pkg::IDX_CYLINDER_LOW)  ? tf_ff.cyl_lo :
      (a_idx == sscf_pkg::IDX_CYLINDER_HIGH) ? tf_ff.cyl_hi :
      (a_idx == sscf_pkg::IDX_DRIVE_HEAD)    ? tf_ff.dh :
      (a_idx == sscf_pkg::IDX_CMD_STATUS)    ? status_byte :
      (a_idx == sscf_pkg::IDX_CONFIG)        ? cfg_ff :
      (a_idx == sscf_pkg::IDX_SEC_STATE)     ? 8'(sec_w) : 8'h00;

  // password selection and compare
  wire sel_master     = ctrl_ff[sscf_pkg::CTRL_ID_BIT];
  wire new_max        = ctrl_ff[sscf_pkg::CTRL_LVL_BIT];
  wire master_refused = sel_master & level_max_ff;
  wire pwd_match      = ~master_refused & (pwd_buf_ff == (sel_master ? master_pwd_ff : user_pwd_ff));

  wire        is_seek  = (cmd_ff[7:4] == sscf_pkg::CMD_SEEK_HI);
  wire [27:0] lba      = {tf_ff.dh[3:0], tf_ff.cyl_hi, tf_ff.cyl_lo, tf_ff.sec_num};
  // head compared at full width, a 4-bit head count of 16 would wrap to 0
  wire        chs_ok   = ({tf_ff.cyl_hi, tf_ff.cyl_lo} < 16'(NUM_CYL))
                       & ({28'h000_0000, tf_ff.dh[3:0]} < NUM_HEAD)
                       & (tf_ff.sec_num != 8'h00) & (tf_ff.sec_num <= 8'(NUM_SPT));
  wire        addr_ok  = tf_ff.dh[sscf_pkg::DH_LBA_BIT] ? (lba < TOTAL_LBA) : chs_ok;

  always_comb begin
    x_abort = 1'b0;
    x_idnf  = 1'b0;
    unique case (cmd_ff)
      sscf_pkg::CMD_SET_PWD:    x_abort = ~sec_en | frozen_ff;
      sscf_pkg::CMD_UNLOCK:     x_abort = ~sec_en | frozen_ff | (tries_ff == 3'h0) | ~pwd_match;
      sscf_pkg::CMD_ERASE_PREP: x_abort = ~sec_en;
      sscf_pkg::CMD_ERASE_UNIT: x_abort = ~sec_en | frozen_ff | (tries_ff == 3'h0) | ~prep_ok_ff | ~pwd_match;
      sscf_pkg::CMD_FREEZE:     x_abort = 1'b0;
      default: begin
        x_abort = ~is_seek;
        x_idnf  = is_seek & ~addr_ok;
      end
    endcase
  end

  wire exec_ok = in_exec & ~x_abort & ~x_idnf;
  wire do_set  = exec_ok & (cmd_ff == sscf_pkg::CMD_SET_PWD);
  wire do_unl  = exec_ok & (cmd_ff == sscf_pkg::CMD_UNLOCK);
  wire do_ers  = exec_ok & (cmd_ff == sscf_pkg::CMD_ERASE_UNIT);
  wire do_frz  = exec_ok & (cmd_ff == sscf_pkg::CMD_FREEZE) & sec_en;
  // failed compare only counts while locked
  wire unl_miss = in_exec & (cmd_ff == sscf_pkg::CMD_UNLOCK) & sec_en & ~frozen_ff & locked_ff
                & (tries_ff != 3'h0) & ~master_refused & ~pwd_match;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      sscf_pkg::ST_IDLE: if (cmd_go) begin
        nxt_state = needs_sector(wbyte) ? sscf_pkg::ST_DATA : sscf_pkg::ST_EXEC;
      end
      sscf_pkg::ST_DATA: if (last_w) begin
        nxt_state = sscf_pkg::ST_EXEC;
      end
      sscf_pkg::ST_EXEC: nxt_state = sscf_pkg::ST_IDLE;
      default:           nxt_state = sscf_pkg::ST_IDLE;
    endcase
  end

  // bus slave: zero wait states, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_idx_ff  <= 4'h0;
      hrdata     <= 32'h0000_0000;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end else begin
      wr_pend_ff <= acc & hwrite;
      wr_idx_ff  <= a_idx;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      if (rd_acc) begin
        hrdata <= {24'h00_0000, rd_byte};
      end
    end
  end

  // task file; host writes ignored while busy or transferring
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tf_ff  <= '{default: sscf_pkg::TF_RESET};
      cfg_ff <= sscf_pkg::CFG_RESET;
      cmd_ff <= 8'h00;
    end else begin
      if (tf_wr && wr_idx_ff == sscf_pkg::IDX_FEATURE_ERROR) tf_ff.feature <= wbyte;
      if (tf_wr && wr_idx_ff == sscf_pkg::IDX_SECTOR_NUMBER) tf_ff.sec_num <= wbyte;
      if (tf_wr && wr_idx_ff == sscf_pkg::IDX_CYLINDER_LOW)  tf_ff.cyl_lo  <= wbyte;
      if (tf_wr && wr_idx_ff == sscf_pkg::IDX_CYLINDER_HIGH) tf_ff.cyl_hi  <= wbyte;
      if (tf_wr && wr_idx_ff == sscf_pkg::IDX_DRIVE_HEAD)    tf_ff.dh      <= wbyte;
      if (tf_wr && wr_idx_ff == sscf_pkg::IDX_CONFIG)        cfg_ff        <= wbyte;
      if (do_frz) begin
        tf_ff.sec_cnt <= 8'h00;
      end else if (tf_wr && wr_idx_ff == sscf_pkg::IDX_SECTOR_COUNT) begin
        tf_ff.sec_cnt <= wbyte;
      end
      if (cmd_go) cmd_ff <= wbyte;
    end
  end

  // sequencer and parameter sector capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff    <= sscf_pkg::ST_IDLE;
      word_cnt_ff <= '0;
      ctrl_ff     <= 16'h0000;
      pwd_buf_ff  <= '0;
    end else begin
      state_ff <= nxt_state;
      if (cmd_go) word_cnt_ff <= '0;
      else if (data_go) word_cnt_ff <= word_cnt_ff + 1'b1;
      // sector layout, words past the password are dropped
      if (data_go && word_cnt_ff == '0) ctrl_ff <= hwdata[15:0];
      if (data_go && word_cnt_ff != '0 && word_cnt_ff <= WC_W'(sscf_pkg::PWD_WORDS)) begin
        pwd_buf_ff[4'(word_cnt_ff - 1'b1) * 16 +: 16] <= hwdata[15:0];
      end
    end
  end

  // status, error and interrupt; completion set wins over status-read clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bsy_ff  <= 1'b0;
      drq_ff  <= 1'b0;
      err_ff  <= 1'b0;
      abrt_ff <= 1'b0;
      idnf_ff <= 1'b0;
      intrq   <= 1'b0;
    end else begin
      if (cmd_go) begin
        bsy_ff  <= ~needs_sector(wbyte);
        drq_ff  <= needs_sector(wbyte);
        err_ff  <= 1'b0;
        abrt_ff <= 1'b0;
        idnf_ff <= 1'b0;
      end else if (last_w) begin
        bsy_ff <= 1'b1;
        drq_ff <= 1'b0;
      end else if (in_exec) begin
        bsy_ff  <= 1'b0;
        err_ff  <= x_abort | x_idnf;
        abrt_ff <= x_abort;
        idnf_ff <= x_idnf;
      end
      if (in_exec) intrq <= 1'b1;
      else if (sts_rd || cmd_go) intrq <= 1'b0;
    end
  end

  // volatile security state, cleared by hardware reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frozen_ff    <= 1'b0;
      locked_ff    <= 1'b0;
      load_lock_ff <= 1'b1;
      prep_ok_ff   <= 1'b0;
      tries_ff     <= sscf_pkg::UNLOCK_TRIES;
    end else begin
      load_lock_ff <= 1'b0;
      if (do_frz) frozen_ff <= 1'b1;
      // lock taken from enable at reset release
      if (load_lock_ff) locked_ff <= lock_en_ff;
      else if (do_unl || do_ers) locked_ff <= 1'b0;
      // any other command breaks the pair
      if (in_exec) prep_ok_ff <= exec_ok & (cmd_ff == sscf_pkg::CMD_ERASE_PREP);
      if (unl_miss) tries_ff <= tries_ff - 3'h1;
    end
  end

  // stored passwords survive hardware reset, cleared at power-on; erase unit also clears the user password
  always_ff @(posedge hclk or negedge por_n) begin
    if (!por_n) begin
      user_pwd_ff   <= '0;
      master_pwd_ff <= '0;
      lock_en_ff    <= 1'b0;
      level_max_ff  <= 1'b0;
    end else begin
      // user password sets lock and level
      if (do_set && !sel_master) begin
        user_pwd_ff  <= pwd_buf_ff;
        lock_en_ff   <= 1'b1;
        level_max_ff <= new_max;
      end
      // master leaves lock and level alone
      if (do_set && sel_master) master_pwd_ff <= pwd_buf_ff;
      if (do_ers) begin
        user_pwd_ff  <= '0;
        lock_en_ff   <= 1'b0;
        level_max_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      erase_pulse      <= 1'b0;
      wear_level_pulse <= 1'b0;
    end else begin
      erase_pulse      <= do_ers;
      wear_level_pulse <= in_exec & (cmd_ff == sscf_pkg::CMD_FREEZE) & ~sec_en;
    end
  end

  wire ex_set = in_exec & (cmd_ff == sscf_pkg::CMD_SET_PWD);
  wire ex_unl = in_exec & (cmd_ff == sscf_pkg::CMD_UNLOCK);
  wire ex_ers = in_exec & (cmd_ff == sscf_pkg::CMD_ERASE_UNIT);
  wire ex_frz = in_exec & (cmd_ff == sscf_pkg::CMD_FREEZE);

  property p_erase_mismatch;
    @(posedge hclk) disable iff (!hresetn) ex_ers && !pwd_match |=> abrt_ff && err_ff;
  endproperty
  a_erase_mismatch: assert property (p_erase_mismatch) else $error("erase with wrong password not aborted");

  property p_erase_prep;
    @(posedge hclk) disable iff (!hresetn) ex_ers && !prep_ok_ff |=> abrt_ff ##1 !prep_ok_ff;
  endproperty
  a_erase_prep: assert property (p_erase_prep) else $error("erase without prepare not aborted");

  property p_freeze;
    @(posedge hclk) disable iff (!hresetn) ex_frz && sec_en |=> frozen_ff && !err_ff && intrq && tf_ff.sec_cnt == 8'h00;
  endproperty
  a_freeze: assert property (p_freeze) else $error("freeze did not complete frozen with zero count");

  property p_frozen_abort;
    @(posedge hclk) disable iff (!hresetn) (ex_set || ex_unl || ex_ers) && frozen_ff |=> abrt_ff && err_ff;
  endproperty
  a_frozen_abort: assert property (p_frozen_abort) else $error("command not aborted while frozen");

  property p_frozen_sticky;
    @(posedge hclk) disable iff (!hresetn) frozen_ff |=> frozen_ff [*4];
  endproperty
  a_frozen_sticky: assert property (p_frozen_sticky) else $error("frozen state cleared");

  property p_wear;
    @(posedge hclk) disable iff (!hresetn) ex_frz && !sec_en |=> wear_level_pulse && $stable(frozen_ff) ##1 !wear_level_pulse;
  endproperty
  a_wear: assert property (p_wear) else $error("freeze opcode not run as wear level");

  property p_set_user;
    @(posedge hclk) disable iff (!hresetn || !por_n)
      do_set && !sel_master |=> lock_en_ff && user_pwd_ff == $past(pwd_buf_ff) && level_max_ff == $past(new_max);
  endproperty
  a_set_user: assert property (p_set_user) else $error("user password not stored");

  property p_set_master;
    @(posedge hclk) disable iff (!hresetn || !por_n)
      do_set && sel_master |=> master_pwd_ff == $past(pwd_buf_ff) && $stable(lock_en_ff) && $stable(level_max_ff);
  endproperty
  a_set_master: assert property (p_set_master) else $error("master password set changed lock state");

  property p_master_max;
    @(posedge hclk) disable iff (!hresetn) ex_unl && sel_master && level_max_ff |=> abrt_ff && $stable(tries_ff);
  endproperty
  a_master_max: assert property (p_master_max) else $error("master unlock accepted at maximum level");

  property p_tries_dec;
    @(posedge hclk) disable iff (!hresetn) unl_miss |=> tries_ff == $past(tries_ff) - 3'h1 && abrt_ff;
  endproperty
  a_tries_dec: assert property (p_tries_dec) else $error("failed unlock did not decrement counter");

  property p_tries_zero;
    @(posedge hclk) disable iff (!hresetn) (ex_unl || ex_ers) && tries_ff == 3'h0 |=> abrt_ff && locked_ff == $past(locked_ff);
  endproperty
  a_tries_zero: assert property (p_tries_zero) else $error("command accepted with counter exhausted");

  property p_unlocked_keep;
    @(posedge hclk) disable iff (!hresetn) ex_unl && !locked_ff |=> $stable(tries_ff);
  endproperty
  a_unlocked_keep: assert property (p_unlocked_keep) else $error("counter moved while unlocked");

  property p_seek;
    @(posedge hclk) disable iff (!hresetn) in_exec && is_seek |=> err_ff == !$past(addr_ok) && idnf_ff == err_ff;
  endproperty
  a_seek: assert property (p_seek) else $error("seek range check wrong");

  property p_complete;
    @(posedge hclk) disable iff (!hresetn) in_exec |=> !bsy_ff && !drq_ff && intrq && state_ff == sscf_pkg::ST_IDLE;
  endproperty
  a_complete: assert property (p_complete) else $error("command did not complete");

  c_freeze:  cover property (@(posedge hclk) disable iff (!hresetn) do_frz);
  c_unlock:  cover property (@(posedge hclk) disable iff (!hresetn) do_unl && locked_ff);
  c_erase:   cover property (@(posedge hclk) disable iff (!hresetn) do_ers);
  c_seekerr: cover property (@(posedge hclk) disable iff (!hresetn) in_exec && x_idnf);

endmodule

/* sscf_host.sv */
module sscf_host (
  // clock and bus answer
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // bus request
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  int stalls;

  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    stalls = 0;
  end

  // a stuck slave is counted, not waited on forever
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (n >= 50) stalls++;
  endtask

  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
endmodule

/* storage_security_command_fsm_bench.sv */
module storage_security_command_fsm_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned SW = 32;
  logic        hclk, hresetn, por_n, hsel, hwrite, hreadyout, hresp;
  logic        intrq, erase_pulse, wear_level_pulse;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int          bad_count, comparisons, erases, wears;

  initial hclk = 1'b0;
  always #5 hclk = ~hclk;

  sscf_security_cmd #(.SECTOR_WORDS(SW)) DUT (
    .hclk(hclk), .hresetn(hresetn), .por_n(por_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .intrq(intrq),
    .erase_pulse(erase_pulse), .wear_level_pulse(wear_level_pulse));

  sscf_host host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  always @(negedge hclk) begin
    if (erase_pulse === 1'b1) erases++;
    if (wear_level_pulse === 1'b1) wears++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    bad_count += host.stalls;
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] i, input logic [31:0] d);
    host.xfer(1'b1, {26'h0, i, 2'h0}, d, rd);
  endtask

  task automatic rr(input logic [3:0] i);
    host.xfer(1'b0, {26'h0, i, 2'h0}, 32'h0, rd);
  endtask

  task automatic sec(input logic [6:0] exp);
    rr(sscf_pkg::IDX_SEC_STATE);
    check(rd, {25'h0, exp});
  endtask

  task automatic hw_rst();
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
  endtask

  // sector commands get word 0 = control, words 1-16 = password
  task automatic cmd(input logic [7:0] op, input logic [15:0] ctl, input logic [15:0] pw, input logic [7:0] er);
    int   n;
    logic sect;
    n = 0;
    sect = op inside {sscf_pkg::CMD_SET_PWD, sscf_pkg::CMD_UNLOCK, sscf_pkg::CMD_ERASE_UNIT};
    wr(sscf_pkg::IDX_CMD_STATUS, {24'h0, op});
    if (sect) begin
      do begin
        rr(sscf_pkg::IDX_CMD_STATUS);
        n++;
      end while (rd[sscf_pkg::STS_DRQ] !== 1'b1 && n < 20);
      if (n >= 20) begin
        bad_count++;
        summarize();
      end
      for (int k = 0; k < SW; k++) wr(sscf_pkg::IDX_DATA, {16'h0, (k == 0) ? ctl : (k <= 16) ? pw + 16'(k) : 16'h0});
    end
    while (intrq !== 1'b1 && n < 60) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 60) begin
      bad_count++;
      summarize();
    end
    rr(sscf_pkg::IDX_CMD_STATUS);
    check(rd[sscf_pkg::STS_ERR], er != 8'h0);
    check(intrq, 1'b0);
    rr(sscf_pkg::IDX_FEATURE_ERROR);
    check(rd, {24'h0, er});
  endtask

  task automatic t_regs();
    wr(sscf_pkg::IDX_SECTOR_COUNT, 32'h0000_005A);
    rr(sscf_pkg::IDX_SECTOR_COUNT);
    check(rd, 32'h0000_005A);
    rr(sscf_pkg::IDX_CONFIG);
    check(rd, {24'h0, sscf_pkg::CFG_RESET});
    sec(7'h05);
    host.xfer(1'b0, 32'h0000_0040, 32'h0, rd);
    check(rd, 32'h0);
    check({hreadyout, hresp}, 2'b10);
    cmd(8'hF6, 16'h0, 16'h0, 8'h04);
  endtask

  // {drive_head, cyl_high, cyl_low, sector_number}; chs then lba
  task automatic t_seek();
    logic [31:0] sk [6];
    logic [5:0]  bad;
    sk = '{32'h0003_D301, 32'h0003_D401, 32'h0F00_0020, 32'h0000_0021, 32'h4007_A7FF, 32'h4007_A800};
    bad = 6'b101010;
    for (int k = 0; k < 6; k++) begin
      wr(sscf_pkg::IDX_DRIVE_HEAD, {24'h0, sk[k][31:24]});
      wr(sscf_pkg::IDX_CYLINDER_HIGH, {24'h0, sk[k][23:16]});
      wr(sscf_pkg::IDX_CYLINDER_LOW, {24'h0, sk[k][15:8]});
      wr(sscf_pkg::IDX_SECTOR_NUMBER, {24'h0, sk[k][7:0]});
      cmd({sscf_pkg::CMD_SEEK_HI, 4'(k)}, 16'h0, 16'h0, bad[k] ? 8'h10 : 8'h00);
    end
  endtask

  task automatic t_erase();
    cmd(sscf_pkg::CMD_SET_PWD, 16'h0000, 16'h1234, 8'h00);
    sec(7'h15);
    cmd(sscf_pkg::CMD_ERASE_UNIT, 16'h0, 16'h1234, 8'h04);
    cmd(sscf_pkg::CMD_ERASE_PREP, 16'h0, 16'h0, 8'h00);
    cmd(sscf_pkg::CMD_ERASE_UNIT, 16'h0, 16'h4321, 8'h04);
    cmd(sscf_pkg::CMD_ERASE_PREP, 16'h0, 16'h0, 8'h00);
    cmd(8'h70, 16'h0, 16'h0, 8'h10);
    cmd(sscf_pkg::CMD_ERASE_UNIT, 16'h0, 16'h1234, 8'h04);
    cmd(sscf_pkg::CMD_ERASE_PREP, 16'h0, 16'h0, 8'h00);
    cmd(sscf_pkg::CMD_ERASE_UNIT, 16'h0, 16'h1234, 8'h00);
    check(erases, 1);
    sec(7'h05);
  endtask

  task automatic t_unlock();
    cmd(sscf_pkg::CMD_SET_PWD, 16'h0001, 16'hAAAA, 8'h00);
    sec(7'h05);
    cmd(sscf_pkg::CMD_SET_PWD, 16'h0100, 16'h5555, 8'h00);
    sec(7'h1D);
    hw_rst();
    sec(7'h3D);
    cmd(sscf_pkg::CMD_UNLOCK, 16'h0001, 16'hAAAA, 8'h04);
    sec(7'h3D);
    for (int k = 0; k < 5; k++) begin
      cmd(sscf_pkg::CMD_UNLOCK, 16'h0, 16'h0BAD, 8'h04);
      sec(7'h3C - 7'(k));
    end
    cmd(sscf_pkg::CMD_UNLOCK, 16'h0, 16'h5555, 8'h04);
    cmd(sscf_pkg::CMD_ERASE_PREP, 16'h0, 16'h0, 8'h00);
    cmd(sscf_pkg::CMD_ERASE_UNIT, 16'h0, 16'h5555, 8'h04);
    hw_rst();
    sec(7'h3D);
    cmd(sscf_pkg::CMD_UNLOCK, 16'h0, 16'h5555, 8'h00);
    cmd(sscf_pkg::CMD_UNLOCK, 16'h0, 16'h0BAD, 8'h04);
    sec(7'h1D);
    cmd(sscf_pkg::CMD_SET_PWD, 16'h0000, 16'h5555, 8'h00);
    hw_rst();
    sec(7'h35);
    cmd(sscf_pkg::CMD_UNLOCK, 16'h0001, 16'hAAAA, 8'h00);
    sec(7'h15);
  endtask

  task automatic t_freeze();
    wr(sscf_pkg::IDX_SECTOR_COUNT, 32'h0000_0033);
    cmd(sscf_pkg::CMD_FREEZE, 16'h0, 16'h0, 8'h00);
    rr(sscf_pkg::IDX_SECTOR_COUNT);
    check(rd, 32'h0);
    sec(7'h55);
    cmd(sscf_pkg::CMD_SET_PWD, 16'h0, 16'h1111, 8'h04);
    cmd(sscf_pkg::CMD_UNLOCK, 16'h0, 16'h5555, 8'h04);
    cmd(sscf_pkg::CMD_ERASE_PREP, 16'h0, 16'h0, 8'h00);
    cmd(sscf_pkg::CMD_ERASE_UNIT, 16'h0, 16'h5555, 8'h04);
    cmd(sscf_pkg::CMD_FREEZE, 16'h0, 16'h0, 8'h00);
    sec(7'h55);
    hw_rst();
    sec(7'h35);
    wr(sscf_pkg::IDX_CONFIG, 32'h0);
    cmd(sscf_pkg::CMD_FREEZE, 16'h0, 16'h0, 8'h00);
    check(wears, 1);
    sec(7'h35);
  endtask

  initial begin
    hresetn = 1'b0;
    por_n = 1'b0;
    bad_count = 0;
    comparisons = 0;
    erases = 0;
    wears = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    por_n <= 1'b1;
    repeat (2) @(posedge hclk);
    t_regs();
    t_seek();
    t_erase();
    t_unlock();
    t_freeze();
    summarize();
  end
endmodule
